// >>> hdl/clock_reset_gen_pll_watchdog.sv
/*
  Clock and reset generator control logic: PLL dividers and filter mode, lock
  and track flags, system clock switch, clock monitor, clock quality checker,
  watchdog with windowed mode and factory test registers, behind an APB slave.
  Assumes pclk is the oscillator clock, and that the analogue loop supplies
  divider ticks and tolerance detector levels from outside this domain.
*/
// Register access over APB is this design's own decision.
`timescale 1ns/1ns
`include "crg_defines.svh"
module clock_reset_gen_pll_watchdog #(
  parameter int CHK_WINDOW = `CHK_WINDOW, // VCO cycles per check window
  parameter int CHK_OSC_OK = `CHK_OSC_OK, // Oscillator edges for good clock
  parameter int WD_SHIFT = 0              // Shortens watchdog periods in sim
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic special_mode,
  input wire logic por_event,
  input wire logic lvr_event,
  input wire logic stop_wake,
  input wire logic cm_fail,
  input wire logic wdog_gate,
  input wire logic vco_tick,
  input wire logic osc_edge,
  input wire logic fb_edge,
  input wire crg_pkg::pll_stat_t pll_stat,
  output logic ref_tick,
  output logic fb_tick,
  output logic pll_en,
  output logic vreg_en,
  output logic filter_acq,
  output logic sys_from_pll,
  output logic clk_freeze,
  output logic self_clock,
  output logic lock_irq,
  output crg_pkg::rst_req_t rst_req
);
  // Input synchronisers for asynchronous pins
  logic [1:0] s1_ff, s2_ff, s3_ff, s4_ff, s5_ff, s6_ff, s7_ff;
  logic [3:0] st1_ff, st2_ff;
  logic fb_d_ff, vco_d_ff, osc_d_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_ff <= 2'h0; s2_ff <= 2'h0; s3_ff <= 2'h0; s4_ff <= 2'h0;
      s5_ff <= 2'h0; s6_ff <= 2'h0; s7_ff <= 2'h0;
      st1_ff <= 4'h0; st2_ff <= 4'h0;
      fb_d_ff <= 1'b0; vco_d_ff <= 1'b0; osc_d_ff <= 1'b0;
    end else begin
      s1_ff <= {s1_ff[0], cm_fail};
      s2_ff <= {s2_ff[0], stop_wake};
      s3_ff <= {s3_ff[0], fb_edge};
      s4_ff <= {s4_ff[0], vco_tick};
      s5_ff <= {s5_ff[0], osc_edge};
      s6_ff <= {s6_ff[0], lvr_event};
      s7_ff <= {s7_ff[0], por_event};
      st1_ff <= pll_stat;
      st2_ff <= st1_ff;
      fb_d_ff <= s3_ff[1];
      vco_d_ff <= s4_ff[1];
      osc_d_ff <= s5_ff[1];
    end
  end
  wire logic cm_fail_s = s1_ff[1];
  wire logic fb_rise = s3_ff[1] & ~fb_d_ff;
  wire logic vco_rise = s4_ff[1] & ~vco_d_ff;
  wire logic osc_rise = s5_ff[1] & ~osc_d_ff;
  wire logic chk_trig = s2_ff[1] | s6_ff[1] | s7_ff[1] | cm_fail_s;
  crg_pkg::pll_stat_t st;
  assign st = st2_ff;

  // Register state and next values
  logic [5:0] mult_ff, nxt_mult;
  logic [3:0] refdiv_ff, nxt_refdiv;
  logic [7:0] pllctl_ff, nxt_pllctl;
  logic [7:0] wdctl_ff, nxt_wdctl;
  logic [7:0] fbyp_ff, nxt_fbyp, fct_ff, nxt_fct;
  logic pll_clock_select_ff, nxt_pll_clock_select, lock_irq_enable_ff, nxt_lock_irq_enable;
  logic lockif_ff, nxt_lockif, lock_ff, nxt_lock, track_ff, nxt_track;
  logic scm_ff, nxt_scm, armed_ff, nxt_armed;
  logic [24:0] wcnt_ff, nxt_wcnt;
  logic [31:0] prdata_ff, nxt_prdata;
  logic pready_ff, nxt_pready; // Wait state: high on the completing cycle
  logic wrst_ff, nxt_wrst, crst_ff, nxt_crst;
  crg_pkg::sw_state_t sw_ff, nxt_sw;
  logic [3:0] swc_ff, nxt_swc;
  logic [3:0] rcnt_ff, nxt_rcnt;
  logic [6:0] fcnt_ff, nxt_fcnt;
  logic rtick_ff, nxt_rtick, ftick_ff, nxt_ftick;
  logic chk_ff, nxt_chk;
  logic [15:0] win_ff, nxt_win;
  logic [12:0] oscn_ff, nxt_oscn;

  // Watchdog period from rate select
  logic [2:0] rate;
  logic [24:0] period;
  assign rate = wdctl_ff[`WDCTL_RATE];
  always_comb begin
    period = 25'h0;
    unique case (rate)
      3'h1: period = `WD_P1;
      3'h2: period = `WD_P2;
      3'h3: period = `WD_P3;
      3'h4: period = `WD_P4;
      3'h5: period = `WD_P5;
      3'h6: period = `WD_P6;
      3'h7: period = `WD_P7;
      default: period = 25'h0;
    endcase
    period = period >> WD_SHIFT;
  end

  // APB decode; one wait state, so registered read data stands at the completing edge
  wire logic acc = psel & penable;
  wire logic wr = acc & pwrite & pready_ff;
  wire logic [7:0] wb = pwdata[7:0];

  // Control registers, watchdog, flags and read data
  always_comb begin
    nxt_mult = mult_ff; nxt_refdiv = refdiv_ff; nxt_pllctl = pllctl_ff;
    nxt_wdctl = wdctl_ff; nxt_fbyp = fbyp_ff; nxt_fct = fct_ff;
    nxt_pll_clock_select = pll_clock_select_ff; nxt_lock_irq_enable = lock_irq_enable_ff; nxt_lockif = lockif_ff;
    nxt_lock = lock_ff; nxt_track = track_ff; nxt_scm = scm_ff;
    nxt_armed = armed_ff; nxt_wcnt = wcnt_ff; nxt_prdata = 32'h0;
    nxt_wrst = 1'b0; nxt_crst = 1'b0;
    // Ready on the second access cycle only
    nxt_pready = acc & ~pready_ff;
    // Lock flag from hysteresis tolerances
    if (st.lock_in) nxt_lock = 1'b1;
    else if (st.unlock_out) nxt_lock = 1'b0;
    // Filter mode: auto by detector, else acquisition bit
    if (pllctl_ff[`PLLCTL_AUTO]) begin
      if (st.trk_in) nxt_track = 1'b1;
      else if (st.trk_out) nxt_track = 1'b0;
    end else begin
      nxt_track = ~pllctl_ff[`PLLCTL_ACQ];
    end
    // Watchdog counts only on gated clock enable
    if (rate != 3'h0 && wdog_gate) begin
      if (wcnt_ff + 25'h1 >= period) begin
        nxt_wrst = 1'b1;
        nxt_wcnt = 25'h0;
      end else begin
        nxt_wcnt = wcnt_ff + 25'h1;
      end
    end
    // Clock monitor fail
    if (cm_fail_s && pllctl_ff[`PLLCTL_CME]) begin
      if (pllctl_ff[`PLLCTL_SELF_CLOCK_ENABLE]) begin
        nxt_scm = 1'b1;
        nxt_pll_clock_select = 1'b0;
      end else begin
        nxt_crst = 1'b1;
      end
    end else if (scm_ff && chk_ff && oscn_ff >= 13'(CHK_OSC_OK)) begin
      nxt_scm = 1'b0;
    end
    // Register writes
    if (wr) begin
      unique case (paddr)
        `OFF_MULT: nxt_mult = pwdata[5:0];
        `OFF_REFDIV: nxt_refdiv = pwdata[3:0];
        `OFF_FLAGS: if (wb[`FLG_LOCKIF]) nxt_lockif = 1'b0;
        `OFF_CLKSEL: begin
          nxt_lock_irq_enable = wb[`CLKSEL_LOCK_IRQ_ENABLE];
          if (!scm_ff) nxt_pll_clock_select = wb[`CLKSEL_PLL_CLOCK_SELECT];
        end
        `OFF_PLLCTL: begin
          nxt_pllctl = wb;
          if (pll_clock_select_ff) nxt_pllctl[`PLLCTL_PLL_POWER_ON] = 1'b1;
          if (scm_ff) nxt_pllctl[`PLLCTL_SELF_CLOCK_ENABLE] = 1'b1;
        end
        `OFF_WDCTL: begin
          nxt_wdctl = {wb[`WDCTL_WIN], 4'h0, wb[`WDCTL_RATE]};
          nxt_wcnt = 25'h0;
          nxt_armed = 1'b0;
        end
        `OFF_FBYP: if (special_mode) nxt_fbyp = wb;
        `OFF_FCTEST: if (special_mode) nxt_fct = wb;
        `OFF_ARM: begin
          if (rate != 3'h0) begin
            if (wdctl_ff[`WDCTL_WIN] && wcnt_ff < period - (period >> 2)) begin
              nxt_wrst = 1'b1;
              nxt_wcnt = 25'h0;
            end else if (wb == `KEY_FIRST) begin
              nxt_armed = 1'b1;
            end else if (wb == `KEY_SECOND) begin
              if (armed_ff) begin
                nxt_wcnt = 25'h0;
                nxt_armed = 1'b0;
              end
            end else begin
              nxt_wrst = 1'b1;
              nxt_wcnt = 25'h0;
            end
          end
        end
        default: ;
      endcase
    end
    // Lock toggle sets the sticky flag; set wins over clear
    if (lock_ff != nxt_lock) nxt_lockif = 1'b1;
    // Read data
    if (acc && !pwrite && !pready_ff) begin
      unique case (paddr)
        `OFF_MULT: nxt_prdata = {26'h0, mult_ff};
        `OFF_REFDIV: nxt_prdata = {28'h0, refdiv_ff};
        `OFF_FLAGS: nxt_prdata = {27'h0, lockif_ff, lock_ff, track_ff, 1'b0, scm_ff};
        `OFF_CLKSEL: nxt_prdata = {24'h0, pll_clock_select_ff, 5'h0, lock_irq_enable_ff, 1'b0};
        `OFF_PLLCTL: nxt_prdata = {24'h0, pllctl_ff};
        `OFF_WDCTL: nxt_prdata = {24'h0, wdctl_ff};
        `OFF_FBYP: nxt_prdata = {24'h0, special_mode ? fbyp_ff : `FBYP_FIXED};
        `OFF_FCTEST: nxt_prdata = {24'h0, special_mode ? fct_ff : `FCTEST_FIXED};
        default: nxt_prdata = 32'h0;
      endcase
    end
  end

  // Dividers, clock switch and quality checker
  always_comb begin
    nxt_rcnt = rcnt_ff; nxt_fcnt = fcnt_ff; nxt_rtick = 1'b0; nxt_ftick = 1'b0;
    nxt_sw = sw_ff; nxt_swc = swc_ff; nxt_chk = chk_ff; nxt_win = win_ff;
    nxt_oscn = oscn_ff;
    // Reference divide by field plus one, on oscillator clock
    if (rcnt_ff >= refdiv_ff) begin
      nxt_rcnt = 4'h0;
      nxt_rtick = 1'b1;
    end else begin
      nxt_rcnt = rcnt_ff + 4'h1;
    end
    // Feedback divide: 2*(m+1) PLL edges
    if (fb_rise) begin
      if (fcnt_ff >= {mult_ff, 1'b1}) begin
        nxt_fcnt = 7'h0;
        nxt_ftick = 1'b1;
      end else begin
        nxt_fcnt = fcnt_ff + 7'h1;
      end
    end
    // Freeze while system clock source changes
    unique case (sw_ff)
      crg_pkg::SW_IDLE: if (pll_clock_select_ff != sys_from_pll) begin
        nxt_sw = crg_pkg::SW_FREEZE;
        nxt_swc = `SWITCH_CYC - 4'h1;
      end
      crg_pkg::SW_FREEZE: if (swc_ff == 4'h0) nxt_sw = crg_pkg::SW_DONE;
        else nxt_swc = swc_ff - 4'h1;
      crg_pkg::SW_DONE: nxt_sw = crg_pkg::SW_IDLE;
    endcase
    // Quality check windows restart until oscillator passes
    if (chk_trig) begin
      nxt_chk = 1'b1;
      nxt_win = 16'h0;
      nxt_oscn = 13'h0;
    end else if (chk_ff) begin
      if (oscn_ff >= 13'(CHK_OSC_OK)) begin
        nxt_chk = 1'b0;
      end else if (vco_rise && win_ff >= 16'(CHK_WINDOW - 1)) begin
        nxt_win = 16'h0;
        nxt_oscn = 13'h0;
      end else begin
        if (vco_rise) nxt_win = win_ff + 16'h1;
        if (osc_rise) nxt_oscn = oscn_ff + 13'h1;
      end
    end
  end

  // Registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mult_ff <= 6'h0; refdiv_ff <= 4'h0; pllctl_ff <= `PLLCTL_RST;
      wdctl_ff <= 8'h0; fbyp_ff <= `FBYP_FIXED; fct_ff <= `FCTEST_FIXED;
      pll_clock_select_ff <= 1'b0; lock_irq_enable_ff <= 1'b0; lockif_ff <= 1'b0;
      lock_ff <= 1'b0; track_ff <= 1'b0; scm_ff <= 1'b0; armed_ff <= 1'b0;
      wcnt_ff <= 25'h0; prdata_ff <= 32'h0; wrst_ff <= 1'b0; crst_ff <= 1'b0;
      sw_ff <= crg_pkg::SW_IDLE; swc_ff <= 4'h0; rcnt_ff <= 4'h0;
      fcnt_ff <= 7'h0; rtick_ff <= 1'b0; ftick_ff <= 1'b0;
      chk_ff <= 1'b1; win_ff <= 16'h0; oscn_ff <= 13'h0;
      sys_from_pll <= 1'b0;
      pready_ff <= 1'b0;
    end else begin
      mult_ff <= nxt_mult; refdiv_ff <= nxt_refdiv; pllctl_ff <= nxt_pllctl;
      wdctl_ff <= nxt_wdctl; fbyp_ff <= nxt_fbyp; fct_ff <= nxt_fct;
      pll_clock_select_ff <= nxt_pll_clock_select; lock_irq_enable_ff <= nxt_lock_irq_enable; lockif_ff <= nxt_lockif;
      lock_ff <= nxt_lock; track_ff <= nxt_track; scm_ff <= nxt_scm;
      armed_ff <= nxt_armed; wcnt_ff <= nxt_wcnt; prdata_ff <= nxt_prdata;
      wrst_ff <= nxt_wrst; crst_ff <= nxt_crst; sw_ff <= nxt_sw; swc_ff <= nxt_swc;
      rcnt_ff <= nxt_rcnt; fcnt_ff <= nxt_fcnt; rtick_ff <= nxt_rtick;
      ftick_ff <= nxt_ftick; chk_ff <= nxt_chk; win_ff <= nxt_win;
      oscn_ff <= nxt_oscn;
      pready_ff <= nxt_pready;
      if (sw_ff == crg_pkg::SW_DONE) sys_from_pll <= pll_clock_select_ff;
    end
  end

  // Output flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_tick <= 1'b0; fb_tick <= 1'b0; pll_en <= 1'b1; vreg_en <= 1'b1;
      filter_acq <= 1'b1; clk_freeze <= 1'b0; self_clock <= 1'b0;
      lock_irq <= 1'b0; rst_req <= '0;
    end else begin
      ref_tick <= rtick_ff;
      fb_tick <= ftick_ff;
      pll_en <= pllctl_ff[`PLLCTL_PLL_POWER_ON] | nxt_chk;
      vreg_en <= 1'b1;
      filter_acq <= ~nxt_track;
      clk_freeze <= (nxt_sw == crg_pkg::SW_FREEZE);
      self_clock <= nxt_scm;
      lock_irq <= lock_irq_enable_ff & lockif_ff;
      rst_req <= '{wdog: wrst_ff, cmon: crst_ff};
    end
  end
  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = 1'b0;
endmodule

// >>> hdl/crg_defines.svh
/*
  Constants of the clock and reset generator: register offsets, field positions,
  reset values and timing counts.
  Assumes inclusion by bare name from the design module, the checker and the bench.
*/
`ifndef CRG_DEFINES_SVH
`define CRG_DEFINES_SVH
// Register byte offsets (index times four)
`define OFF_MULT 12'h000
`define OFF_REFDIV 12'h004
`define OFF_FLAGS 12'h008
`define OFF_CLKSEL 12'h00c
`define OFF_PLLCTL 12'h010
`define OFF_WDCTL 12'h014
`define OFF_FBYP 12'h018
`define OFF_FCTEST 12'h01c
`define IDX_ARM 8'h0b
`define OFF_ARM 12'h02c
// Watchdog arm keys
`define KEY_FIRST 8'h55
`define KEY_SECOND 8'haa
// Fixed reads of factory registers outside special modes
`define FBYP_FIXED 8'h00
`define FCTEST_FIXED 8'h80
// Field positions, control register
`define PLLCTL_CME 7
`define PLLCTL_PLL_POWER_ON 6
`define PLLCTL_AUTO 5
`define PLLCTL_ACQ 4
`define PLLCTL_SELF_CLOCK_ENABLE 0
`define PLLCTL_RST 8'hf1
`define WDCTL_WIN 7
`define WDCTL_RATE 2:0
// Clock select register fields
`define CLKSEL_PLL_CLOCK_SELECT 7
`define CLKSEL_LOCK_IRQ_ENABLE 1
// Watchdog timeout lengths per rate code, oscillator cycles
`define WD_P1 25'h0004000
`define WD_P2 25'h0010000
`define WD_P3 25'h0040000
`define WD_P4 25'h0100000
`define WD_P5 25'h0400000
`define WD_P6 25'h0800000
`define WD_P7 25'h1000000
// Flag register fields
`define FLG_LOCKIF 4
`define FLG_LOCK 3
`define FLG_TRACK 2
`define FLG_SCM 0
// Clock switch length in pclk cycles: 4 osc plus 4 pll cycles
`define SWITCH_CYC 4'h8
// Quality checker figures
`define CHK_WINDOW 50000
`define CHK_OSC_OK 4096
`endif

// >>> hdl/crg_pkg.sv
/*
  Types of the clock and reset generator.
  Assumes crg_defines.svh is on the include path.
*/
package crg_pkg;
  // PLL status from the analogue lock detector
  typedef struct packed {
    logic lock_in;   // Within lock tolerance
    logic unlock_out; // Outside unlock tolerance
    logic trk_in;    // Within track tolerance
    logic trk_out;   // Outside untrack tolerance
  } pll_stat_t;
  // Reset causes sent to the reset generator
  typedef struct packed {
    logic wdog;   // Watchdog reset
    logic cmon;   // Clock monitor reset
  } rst_req_t;
  // Clock switch state machine
  typedef enum logic [2:0] {
    SW_IDLE = 3'h1,
    SW_FREEZE = 3'h2,
    SW_DONE = 3'h4
  } sw_state_t;
endpackage

// >>> sim/clock_reset_gen_pll_watchdog_properties.sv
/*
  Port checker of the clock and reset generator.
  Assumes binding to the top module; one clock domain.
*/
`timescale 1ns/1ns
`include "crg_defines.svh"
module clock_reset_gen_pll_watchdog_properties (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic special_mode,
  input wire logic pll_en,
  input wire logic vreg_en,
  input wire logic sys_from_pll,
  input wire logic clk_freeze,
  input wire logic self_clock,
  input wire crg_pkg::rst_req_t rst_req
);
  logic acc; // Completing edge of any transfer
  logic wr_arm; // Arm register write
  logic [2:0] rate_ff; // Rate as last written
  logic [2:0] nxt_rate;
  assign acc = psel && penable && pready;
  assign wr_arm = acc && pwrite && paddr == `OFF_ARM;
  // Rate copy, taken at every completed control write
  always_comb begin
    nxt_rate = rate_ff;
    if (acc && pwrite && paddr == `OFF_WDCTL) begin
      nxt_rate = pwdata[2:0];
    end
  end
  // Rate register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rate_ff <= 3'h0;
    end else begin
      rate_ff <= nxt_rate;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_bad_arm;
    wr_arm && rate_ff != 3'h0 && pwdata[7:0] != `KEY_FIRST && pwdata[7:0] != `KEY_SECOND
      |-> ##[2:3] rst_req.wdog;
  endproperty
  a_bad_arm: assert property (p_bad_arm) else $error("bad arm value without reset");
  property p_off_arm;
    wr_arm && rate_ff == 3'h0 |-> ##1 !rst_req.wdog [*3];
  endproperty
  a_off_arm: assert property (p_off_arm) else $error("arm write acted while off");
  property p_wd_pulse;
    $rose(rst_req.wdog) |=> !rst_req.wdog;
  endproperty
  a_wd_pulse: assert property (p_wd_pulse) else $error("watchdog reset too long");
  property p_fbyp;
    acc && !pwrite && paddr == `OFF_FBYP && !special_mode |-> prdata == 32'h00000000;
  endproperty
  a_fbyp: assert property (p_fbyp) else $error("bypass test register not fixed");
  property p_fctest;
    acc && !pwrite && paddr == `OFF_FCTEST && !special_mode |-> prdata == 32'h00000080;
  endproperty
  a_fctest: assert property (p_fctest) else $error("clock test register not fixed");
  property p_pll_hold;
    sys_from_pll |-> pll_en;
  endproperty
  a_pll_hold: assert property (p_pll_hold) else $error("loop off while selected");
  property p_freeze;
    $rose(clk_freeze) |-> ##[1:9] !clk_freeze;
  endproperty
  a_freeze: assert property (p_freeze) else $error("clock switch too long");
  property p_self;
    self_clock |-> pll_en;
  endproperty
  a_self: assert property (p_self) else $error("self clock without loop");
  property p_chk_on;
    $rose(presetn) |-> pll_en && vreg_en;
  endproperty
  a_chk_on: assert property (p_chk_on) else $error("check without loop power");
endmodule
bind clock_reset_gen_pll_watchdog clock_reset_gen_pll_watchdog_properties props_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .special_mode(special_mode),
  .pll_en(pll_en), .vreg_en(vreg_en), .sys_from_pll(sys_from_pll),
  .clk_freeze(clk_freeze), .self_clock(self_clock), .rst_req(rst_req));

// >>> sim/pll_loop_model.sv
/*
  Behavioural analogue loop: oscillator, feedback and VCO ticks, tolerance levels.
  Assumes pll_en powers it; LOCK_CYC sets prompt or slow lock.
*/
`timescale 1ns/1ns
module pll_loop_model #(
  parameter int LOCK_CYC = 20 // Cycles from power to lock
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pll_en,
  output logic osc_edge,
  output logic fb_edge,
  output logic vco_tick,
  output crg_pkg::pll_stat_t pll_stat
);
  int cnt; // Cycles since power
  // Loop stands still when off, so no feedback or VCO tick leaks out of a dead loop
  always @(posedge pclk or negedge presetn) begin
    if (!presetn || !pll_en) begin
      cnt <= 0;
      fb_edge <= 1'b0;
      vco_tick <= 1'b0;
    end else begin
      cnt <= cnt + 1;
      fb_edge <= cnt[1];
      vco_tick <= !vco_tick;
    end
    osc_edge <= presetn && !osc_edge;
  end
  // Tolerance levels; in and out are never true together
  always_comb begin
    pll_stat.lock_in = cnt >= LOCK_CYC;
    pll_stat.unlock_out = cnt < LOCK_CYC / 2;
    pll_stat.trk_in = cnt >= LOCK_CYC;
    pll_stat.trk_out = cnt < LOCK_CYC / 2;
  end
endmodule

// >>> sim/clock_reset_gen_pll_watchdog_test.sv
/*
  Self-checking bench of the clock and reset generator.
  Assumes the loop model and the bound checker are compiled alongside.
*/
`timescale 1ns/1ns
`include "crg_defines.svh"
module clock_reset_gen_pll_watchdog_test;
  logic pclk, presetn, psel, penable, pwrite, special_mode, cm_fail, wdog_gate;
  logic chk_evt, pready, pslverr, osc_edge, fb_edge, vco_tick, ref_tick, fb_tick;
  logic pll_en, vreg_en, filter_acq, sys_from_pll, clk_freeze, self_clock, lock_irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q; // q: last read data
  logic [15:0] seed = 16'h68ac; // Random state
  crg_pkg::pll_stat_t pll_stat;
  crg_pkg::rst_req_t rst_req;
  int fails = 0, num_checks = 0, wd_cnt = 0, cm_cnt = 0, cyc = 0;
  clock_reset_gen_pll_watchdog #(.CHK_WINDOW(50), .CHK_OSC_OK(8), .WD_SHIFT(8))
    clock_reset_gen_pll_watchdog_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .special_mode(special_mode), .por_event(chk_evt),
    .lvr_event(chk_evt), .stop_wake(chk_evt), .cm_fail(cm_fail), .wdog_gate(wdog_gate),
    .vco_tick(vco_tick), .osc_edge(osc_edge), .fb_edge(fb_edge), .pll_stat(pll_stat),
    .ref_tick(ref_tick), .fb_tick(fb_tick), .pll_en(pll_en), .vreg_en(vreg_en),
    .filter_acq(filter_acq), .sys_from_pll(sys_from_pll), .clk_freeze(clk_freeze),
    .self_clock(self_clock), .lock_irq(lock_irq), .rst_req(rst_req));
  pll_loop_model #(.LOCK_CYC(20)) pll_loop_model_inst (.pclk(pclk), .presetn(presetn),
    .pll_en(pll_en), .osc_edge(osc_edge), .fb_edge(fb_edge), .vco_tick(vco_tick),
    .pll_stat(pll_stat));
  // 10 MHz clock
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  // Reset pulse counts and hang limit
  always @(posedge pclk) begin
    cyc++;
    if (rst_req.wdog === 1'b1) wd_cnt++;
    if (rst_req.cmon === 1'b1) cm_cnt++;
    if (cyc == 5000) begin
      fails++;
      stop_test;
    end
  end
  // Sixteen-bit shift register step
  function logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // Random arm value that is never a key
  function logic [31:0] bad_val();
    seed = lfsr(seed);
    // Flip the low bit: inverting a key would give the other key
    if (seed[7:0] == `KEY_FIRST || seed[7:0] == `KEY_SECOND) return {24'h0, seed[7:0] ^ 8'h01};
    return {24'h0, seed[7:0]};
  endfunction
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // One APB transfer; read data taken at the edge where pready is high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task do_reset;
    presetn <= 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    wd_cnt = 0;
    cm_cnt = 0;
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    {presetn, psel, penable, pwrite, special_mode, cm_fail, chk_evt} = '0;
    {paddr, pwdata, wdog_gate} = '0;
    do_reset;
    apb(0, `OFF_WDCTL, 0);
    chk(q, 32'h0);
    apb(0, `OFF_FCTEST, 0);
    chk(q, {24'h0, `FCTEST_FIXED});
    seed = lfsr(seed);
    special_mode <= 1'b1;
    apb(1, `OFF_FBYP, {24'h0, seed[7:0]});
    apb(0, `OFF_FBYP, 0);
    chk(q, {24'h0, seed[7:0]});
    special_mode <= 1'b0;
    apb(1, `OFF_FBYP, {24'h0, ~seed[7:0]});
    apb(0, `OFF_FBYP, 0);
    chk(q, {24'h0, `FBYP_FIXED});
    apb(1, `OFF_ARM, bad_val());
    repeat (5) @(posedge pclk);
    chk(wd_cnt, 0);
    $display("registers done");
    apb(1, `OFF_WDCTL, 32'h1);
    repeat (150) @(posedge pclk);
    chk(wd_cnt, 0);
    wdog_gate <= 1'b1;
    repeat (5) begin
      apb(1, `OFF_ARM, `KEY_FIRST);
      apb(1, `OFF_ARM, `KEY_FIRST);
      apb(1, `OFF_ARM, `KEY_SECOND);
      apb(1, `OFF_ARM, `KEY_SECOND);
    end
    chk(wd_cnt, 0);
    repeat (90) @(posedge pclk);
    chk(wd_cnt, 1);
    repeat (3) apb(1, `OFF_ARM, bad_val());
    repeat (4) @(posedge pclk);
    chk(wd_cnt, 4);
    $display("watchdog done");
    do_reset;
    apb(1, `OFF_WDCTL, 32'h81);
    apb(1, `OFF_ARM, `KEY_FIRST);
    repeat (4) @(posedge pclk);
    chk(wd_cnt, 1);
    do_reset;
    apb(1, `OFF_WDCTL, 32'h81);
    repeat (52) @(posedge pclk);
    apb(1, `OFF_ARM, `KEY_FIRST);
    apb(1, `OFF_ARM, `KEY_SECOND);
    repeat (4) @(posedge pclk);
    chk(wd_cnt, 0);
    apb(1, `OFF_ARM, `KEY_FIRST);
    repeat (4) @(posedge pclk);
    chk(wd_cnt, 1);
    $display("window done");
    do_reset;
    repeat (30) @(posedge pclk);
    apb(1, `OFF_CLKSEL, 32'h82);
    apb(0, `OFF_FLAGS, 0);
    chk(q, 32'h1c);
    repeat (12) @(posedge pclk);
    chk(sys_from_pll, 1);
    chk(lock_irq, 1);
    apb(1, `OFF_FLAGS, 32'h10);
    repeat (2) @(posedge pclk);
    chk(lock_irq, 0);
    apb(1, `OFF_PLLCTL, 32'hb1);
    apb(0, `OFF_PLLCTL, 0);
    chk(q[6], 1);
    // Manual filter mode, acquisition then tracking
    apb(1, `OFF_PLLCTL, 32'h90);
    repeat (2) @(posedge pclk);
    chk(filter_acq, 1);
    apb(1, `OFF_PLLCTL, 32'h80);
    apb(0, `OFF_FLAGS, 0);
    chk(q[2], 1);
    chk(filter_acq, 0);
    $display("switch done");
    do_reset;
    cm_fail <= 1'b1;
    repeat (10) @(posedge pclk);
    chk(self_clock, 1);
    cm_fail <= 1'b0;
    do_reset;
    repeat (30) @(posedge pclk);
    apb(1, `OFF_PLLCTL, 32'hb0);
    repeat (2) @(posedge pclk);
    chk(pll_en, 0);
    chk_evt <= 1'b1;
    repeat (4) @(posedge pclk);
    chk(pll_en, 1);
    chk_evt <= 1'b0;
    cm_fail <= 1'b1;
    repeat (10) @(posedge pclk);
    chk(cm_cnt != 0, 1);
    $display("monitor done");
    stop_test;
  end
endmodule
